// [fpr_ctrl.sv]
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// - Four location-monitor bits, reachable from local bus and backplane port
// - Enabled abort press raises an interrupt at a software-chosen level
// - Abort interrupt leaves on an active-low ISA line
// - Debounced abort button level is readable in the status register
// - Abort source fires on the press edge, bounce filtered to one event
// - Reset button resets on-board devices and asserts processor hard reset
// - Reset button drives backplane system reset only as system controller
// - System controller drives backplane reset on button, power-up, watchdog, software
// - Each driven backplane system reset lasts at least 200 ms
// - Local reset from button, power-up, watchdog, backplane reset or software
// - Local reset works whether or not this board is system controller
// - Local hold bit keeps the board in reset while set
// - Board-fail lamp lights while the failure signal is low, three clocks after the pin
// - Processor lamp lights while processor bus busy is asserted
// - Upper mezzanine lamp follows slot 2 grant, lower follows slot 1
// - Carrier lamps both lit during reset, else follow slot mastership
// - Debug port is asynchronous and powers up as 8N1 at 9600 baud
module fpr_ctrl
  import fpr_pkg::*;
#(
  parameter int CLK_HZ = `FPR_CLK_HZ,
  parameter int SYSRST_CYC =
    (`FPR_SYSRST_MS * CLK_HZ + `FPR_MS_PER_S - 1) / `FPR_MS_PER_S
) (
  // Clock, enable and reset
  input logic clock,
  input logic ce,
  input logic sys_rst,
  // AXI4-Lite write channels
  input logic [`FPR_ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read channels
  input logic [`FPR_ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Board pins and on-board events
  input fpr_pins_t pins,
  input logic watchdog_timeout,
  // Backplane location monitor port
  input logic bp_lm_wr,
  input logic [`FPR_LM_W-1:0] bp_lm_wdata,
  output logic [`FPR_LM_W-1:0] bp_lm_q,
  // Reset outputs
  output logic bp_sysreset_o,
  output logic bp_sysreset_oe,
  output logic local_reset,
  output logic processor_hard_reset_n,
  // Interrupts
  output logic abort_isa_interrupt_n,
  output logic [2:0] abort_irq_level,
  output logic irq,
  // Lamps and serial port format
  output fpr_lamps_t lamps,
  output fpr_ufmt_t port_format_command
);

  localparam logic [`FPR_CNT_W-1:0] LAST_C = `FPR_CNT_W'(SYSRST_CYC - 1);

  // Reset value of the whole state
  localparam fpr_state_t ST_RST = '{
    sync1: '1,
    sync2: '1,
    rs_state: RS_IDLE,
    rs_cnt: '0,
    por: 1'b1,
    ctrl: '0,
    locmon: '0,
    int_stat: '0,
    int_mask: '0,
    deb_lim: `FPR_DEB_RST,
    ufmt: '{parity_en: `FPR_UF_NOPAR, two_stop: `FPR_UF_STOP1,
            len: `FPR_UF_LEN8, div: 16'(`FPR_BAUD_DIV)},
    aw_got: 1'b0,
    w_got: 1'b0,
    awaddr: '0,
    wdata: '0,
    wstrb: '0,
    bvalid: 1'b0,
    bresp: `FPR_RESP_OKAY,
    rvalid: 1'b0,
    rdata: '0,
    rresp: `FPR_RESP_OKAY,
    lamps: '{span_upper_lamp: 1'b1, span_lower_lamp: 1'b1, default: 1'b0},
    drive_sr: 1'b0,
    loc_rst: 1'b1,
    abt_irq: 1'b0,
    irq: 1'b0
  };

  fpr_state_t st_q;
  fpr_state_t st_d;
  logic deb_level;
  logic deb_press;

  if (SYSRST_CYC < 1 || SYSRST_CYC >= (2 ** `FPR_CNT_W)) begin : g_chk
    $error("fpr_ctrl: SYSRST_CYC does not fit the reset counter");
  end

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] fpr_merge(input logic [31:0] old,
                                            input logic [31:0] val,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = val[8*i +: 8];
      end
    end
    return res;
  endfunction

  // True for an address that maps to a register
  function automatic logic fpr_mapped(input logic [`FPR_ADDR_W-1:0] a);
    case (a)
      `FPR_OFF_CTRL, `FPR_OFF_LOCMON, `FPR_OFF_STATUS,
      `FPR_OFF_INT_STAT, `FPR_OFF_INT_MASK, `FPR_OFF_DEBOUNCE,
      `FPR_OFF_PORT_FMT: fpr_mapped = 1'b1;
      default: fpr_mapped = 1'b0;
    endcase
  endfunction

  // Abort button filter, pressed means pin low
  fpr_debounce #(
    .CW(`FPR_DEB_W)
  ) u_abort_deb (
    .clock(clock),
    .ce(ce),
    .sys_rst(sys_rst),
    .din(!st_q.sync2.abort_n),
    .limit(st_q.deb_lim),
    .level(deb_level),
    .press(deb_press)
  );

  // Next state of synchronisers, sequencer, registers and bus
  always_comb begin
    fpr_pins_t s;
    logic src;
    logic bp_rst;
    logic [`FPR_EV_W-1:0] set_ev;
    logic [`FPR_EV_W-1:0] clr_ev;
    logic [31:0] img;
    logic [`FPR_ADDR_W-1:0] ra;
    s = st_q.sync2;
    src = 1'b0;
    bp_rst = 1'b0;
    set_ev = '0;
    clr_ev = '0;
    img = '0;
    ra = s_axi_araddr;
    st_d = st_q;

    // Two-stage pin synchronisers
    st_d.sync1 = pins;
    st_d.sync2 = st_q.sync1;

    // Reset sources
    bp_rst = !s.bp_sysreset_n;
    src = !s.reset_n | st_q.por | watchdog_timeout | st_q.ctrl.sw_sysrst;

    // Minimum-width reset sequencer
    case (st_q.rs_state)
      RS_IDLE: begin
        if (src) begin
          st_d.rs_state = RS_PULSE;
          st_d.rs_cnt = '0;
          st_d.por = 1'b0;
        end
      end
      RS_PULSE: begin
        if (st_q.rs_cnt == LAST_C) begin
          st_d.rs_state = src ? RS_HOLD : RS_IDLE;
        end else begin
          st_d.rs_cnt = st_q.rs_cnt + 1'b1;
        end
      end
      RS_HOLD: begin
        if (!src) begin
          st_d.rs_state = RS_IDLE;
        end
      end
      default: begin
        st_d.rs_state = RS_IDLE;
      end
    endcase

    // Backplane drive only as system controller
    st_d.drive_sr = (st_d.rs_state != RS_IDLE) && s.sys_ctrl;
    // Local reset regardless of controller role
    st_d.loc_rst = (st_d.rs_state != RS_IDLE) | bp_rst;

    // AXI write address and data, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (st_q.aw_got && st_q.w_got) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = fpr_mapped(st_q.awaddr) ? `FPR_RESP_OKAY
                                           : `FPR_RESP_SLVERR;
      case (st_q.awaddr)
        `FPR_OFF_CTRL: begin
          img = fpr_merge(32'(st_q.ctrl), st_q.wdata, st_q.wstrb);
          st_d.ctrl = img[5:0];
        end
        `FPR_OFF_LOCMON: begin
          img = fpr_merge(32'(st_q.locmon), st_q.wdata, st_q.wstrb);
          st_d.locmon = img[`FPR_LM_W-1:0];
        end
        `FPR_OFF_INT_STAT: begin
          img = fpr_merge(32'h00000000, st_q.wdata, st_q.wstrb);
          clr_ev = img[`FPR_EV_W-1:0];
        end
        `FPR_OFF_INT_MASK: begin
          img = fpr_merge(32'(st_q.int_mask), st_q.wdata, st_q.wstrb);
          st_d.int_mask = img[`FPR_EV_W-1:0];
        end
        `FPR_OFF_DEBOUNCE: begin
          img = fpr_merge(32'(st_q.deb_lim), st_q.wdata, st_q.wstrb);
          st_d.deb_lim = img[`FPR_DEB_W-1:0];
        end
        `FPR_OFF_PORT_FMT: begin
          img = fpr_merge(32'(st_q.ufmt), st_q.wdata, st_q.wstrb);
          st_d.ufmt = img[19:0];
        end
        default: begin
          img = '0;
        end
      endcase
    end

    // Backplane write to the monitor bits wins over a local one
    if (bp_lm_wr) begin
      st_d.locmon = bp_lm_wdata;
    end

    // Sticky events, a new event beats a clear in the same cycle
    set_ev[`FPR_EV_ABORT] = deb_press;
    set_ev[`FPR_EV_WDT] = watchdog_timeout;
    set_ev[`FPR_EV_LM] = bp_lm_wr;
    st_d.int_stat = (st_q.int_stat & ~clr_ev) | set_ev;

    // AXI read, data captured at the address handshake
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = fpr_mapped(ra) ? `FPR_RESP_OKAY : `FPR_RESP_SLVERR;
      case (ra)
        `FPR_OFF_CTRL: st_d.rdata = 32'(st_q.ctrl);
        `FPR_OFF_LOCMON: st_d.rdata = 32'(st_q.locmon);
        `FPR_OFF_STATUS: begin
          st_d.rdata = 32'({st_q.drive_sr, st_q.loc_rst,
                            s.sys_ctrl, deb_level});
        end
        `FPR_OFF_INT_STAT: st_d.rdata = 32'(st_q.int_stat);
        `FPR_OFF_INT_MASK: st_d.rdata = 32'(st_q.int_mask);
        `FPR_OFF_DEBOUNCE: st_d.rdata = 32'(st_q.deb_lim);
        `FPR_OFF_PORT_FMT: st_d.rdata = 32'(st_q.ufmt);
        default: st_d.rdata = 32'h00000000;
      endcase
    end

    // Local hold from software
    st_d.loc_rst = st_d.loc_rst | st_d.ctrl.loc_hold;

    // Interrupt outputs
    st_d.abt_irq = st_d.ctrl.abort_en & st_d.int_stat[`FPR_EV_ABORT];
    st_d.irq = |(st_d.int_stat & st_d.int_mask);

    // Lamps
    st_d.lamps.board_fail_lamp = !s.board_fail_n;
    st_d.lamps.cpu_lamp = !s.bus_busy_n;
    st_d.lamps.upper_mezzanine_lamp = !s.pci_gnt_n[1];
    st_d.lamps.lower_mezzanine_lamp = !s.pci_gnt_n[0];
    st_d.lamps.span_upper_lamp = st_d.loc_rst | !s.span_gnt_n[1];
    st_d.lamps.span_lower_lamp = st_d.loc_rst | !s.span_gnt_n[0];
  end

  // State register, frozen while ce is low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= ST_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Bus handshakes
  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // Block outputs
  assign bp_lm_q = st_q.locmon;
  assign bp_sysreset_o = 1'b0;
  assign bp_sysreset_oe = st_q.drive_sr;
  assign local_reset = st_q.loc_rst;
  assign processor_hard_reset_n = !st_q.loc_rst;
  assign abort_isa_interrupt_n = !st_q.abt_irq;
  assign abort_irq_level = st_q.ctrl.abort_lvl;
  assign irq = st_q.irq;
  assign lamps = st_q.lamps;
  assign port_format_command = st_q.ufmt;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  press_sets_stat_a: assert property (
    ce && deb_press |=> st_q.int_stat[`FPR_EV_ABORT])
    else $error("abort press did not set status");

  abort_line_a: assert property (
    abort_isa_interrupt_n == !(st_q.ctrl.abort_en &&
                               st_q.int_stat[`FPR_EV_ABORT]))
    else $error("abort line disagrees with enable and status");

  sysrst_width_a: assert property (
    $past(!sys_rst) && st_q.rs_state == RS_IDLE &&
    $past(st_q.rs_state) == RS_PULSE |-> $past(st_q.rs_cnt) == LAST_C)
    else $error("system reset released before minimum width");

  pulse_runs_a: assert property (
    ce && st_q.rs_state == RS_PULSE && st_q.rs_cnt != LAST_C
    |=> st_q.rs_state == RS_PULSE)
    else $error("reset pulse left early");

  rst_button_a: assert property (
    ce && !st_q.sync2.reset_n |=> st_q.rs_state != RS_IDLE && local_reset
    && !processor_hard_reset_n)
    else $error("reset button did not start reset");

  wdt_sysrst_a: assert property (
    ce && watchdog_timeout && st_q.rs_state == RS_IDLE
    |=> st_q.rs_state == RS_PULSE)
    else $error("watchdog did not start reset");

  drive_role_a: assert property (
    ce && !st_q.sync2.sys_ctrl |=> !bp_sysreset_oe)
    else $error("backplane reset driven while not controller");

  hold_rst_a: assert property (
    st_q.ctrl.loc_hold |-> local_reset && !processor_hard_reset_n)
    else $error("local hold did not keep reset");

  lamp_fail_a: assert property (
    ce |=> lamps.board_fail_lamp == !$past(st_q.sync2.board_fail_n))
    else $error("board fail lamp wrong");

  span_reset_a: assert property (
    local_reset |-> lamps.span_upper_lamp && lamps.span_lower_lamp)
    else $error("carrier lamps dark during reset");

  lm_backplane_a: assert property (
    ce && bp_lm_wr |=> bp_lm_q == $past(bp_lm_wdata))
    else $error("backplane monitor write lost");

endmodule

// [fpr_defs.svh]
`ifndef FPR_DEFS_SVH
`define FPR_DEFS_SVH

// Board clock and reset timing
`define FPR_CLK_HZ 10000000
`define FPR_MS_PER_S 1000
`define FPR_SYSRST_MS 200
`define FPR_CNT_W 24

// Debounce filter
`define FPR_DEB_W 16
`define FPR_DEB_RST 16'h2710

// Debug serial port power-up format
`define FPR_BAUD 9600
`define FPR_BAUD_OVS 16
`define FPR_BAUD_DIV (`FPR_CLK_HZ / (`FPR_BAUD_OVS * `FPR_BAUD))
`define FPR_UF_LEN8 2'h3
`define FPR_UF_STOP1 1'h0
`define FPR_UF_NOPAR 1'h0

// Register byte offsets
`define FPR_ADDR_W 8
`define FPR_OFF_CTRL 8'h00
`define FPR_OFF_LOCMON 8'h04
`define FPR_OFF_STATUS 8'h08
`define FPR_OFF_INT_STAT 8'h0c
`define FPR_OFF_INT_MASK 8'h10
`define FPR_OFF_DEBOUNCE 8'h14
`define FPR_OFF_PORT_FMT 8'h18

// Field widths and event bit positions
`define FPR_LM_W 4
`define FPR_EV_W 3
`define FPR_EV_ABORT 0
`define FPR_EV_WDT 1
`define FPR_EV_LM 2

// AXI responses
`define FPR_RESP_OKAY 2'h0
`define FPR_RESP_SLVERR 2'h2

`endif

// [fpr_pkg.sv]
`include "fpr_defs.svh"

package fpr_pkg;

  // Reset sequencer states
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_PULSE = 2'b01,
    RS_HOLD = 2'b10
  } fpr_rs_t;

  // Pins from the board, all asynchronous to clock
  typedef struct packed {
    logic abort_n;
    logic reset_n;
    logic bp_sysreset_n;
    logic sys_ctrl;
    logic board_fail_n;
    logic bus_busy_n;
    logic [1:0] pci_gnt_n;
    logic [1:0] span_gnt_n;
  } fpr_pins_t;

  // Front panel and carrier lamps, high lights the lamp
  typedef struct packed {
    logic board_fail_lamp;
    logic cpu_lamp;
    logic upper_mezzanine_lamp;
    logic lower_mezzanine_lamp;
    logic span_upper_lamp;
    logic span_lower_lamp;
  } fpr_lamps_t;

  // Control register layout
  typedef struct packed {
    logic loc_hold;
    logic sw_sysrst;
    logic [2:0] abort_lvl;
    logic abort_en;
  } fpr_ctrl_t;

  // Debug serial port format
  typedef struct packed {
    logic parity_en;
    logic two_stop;
    logic [1:0] len;
    logic [15:0] div;
  } fpr_ufmt_t;

  // Whole state of the controller
  typedef struct packed {
    fpr_pins_t sync1;
    fpr_pins_t sync2;
    fpr_rs_t rs_state;
    logic [`FPR_CNT_W-1:0] rs_cnt;
    logic por;
    fpr_ctrl_t ctrl;
    logic [`FPR_LM_W-1:0] locmon;
    logic [`FPR_EV_W-1:0] int_stat;
    logic [`FPR_EV_W-1:0] int_mask;
    logic [`FPR_DEB_W-1:0] deb_lim;
    fpr_ufmt_t ufmt;
    logic aw_got;
    logic w_got;
    logic [`FPR_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    fpr_lamps_t lamps;
    logic drive_sr;
    logic loc_rst;
    logic abt_irq;
    logic irq;
  } fpr_state_t;

endpackage

// [fpr_debounce.sv]
`timescale 1ns/1ns

module fpr_debounce
  import fpr_pkg::*;
#(
  parameter int CW = 16
) (
  // Clock, enable and reset
  input logic clock,
  input logic ce,
  input logic sys_rst,
  // Filtered input
  input logic din,
  input logic [CW-1:0] limit,
  output logic level,
  output logic press
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic level;
    logic press;
  } fpr_deb_state_t;

  fpr_deb_state_t st_q;
  fpr_deb_state_t st_d;

  if (CW < 2) begin : g_chk
    $error("fpr_debounce: CW too small");
  end

  // Accept a new level only after it has stayed put past the limit
  always_comb begin
    st_d = st_q;
    st_d.press = 1'b0;
    if (din == st_q.level) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= limit) begin
      st_d.level = din;
      st_d.press = din;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign level = st_q.level;
  assign press = st_q.press;

endmodule

// [fpr_board_model.sv]
`timescale 1ns/1ns

module fpr_board_model
  import fpr_pkg::*;
(
  // Clock
  input logic clock,
  // Requests from the bench
  input logic press,
  input fpr_pins_t pins_req,
  input logic lm_req,
  input logic [3:0] lm_data,
  // Board and backplane side of the controller
  output fpr_pins_t pins,
  output logic bp_lm_wr,
  output logic [3:0] bp_lm_wdata
);
  logic held_q = 1'b0;
  logic [2:0] bounce_q = 3'h0;
  fpr_pins_t pins_q = '1;
  logic lm_wr_q = 1'b0;
  logic [3:0] lm_data_q = 4'h0;

  // Abort button contacts chatter for five cycles after every change
  always @(posedge clock) begin
    fpr_pins_t nxt;
    nxt = pins_req;
    if (press !== held_q) begin
      held_q <= press;
      bounce_q <= 3'h5;
      nxt.abort_n = ~pins_q.abort_n;
    end else if (bounce_q != 3'h0) begin
      bounce_q <= bounce_q - 3'h1;
      nxt.abort_n = ~pins_q.abort_n;
    end else begin
      nxt.abort_n = ~held_q;
    end
    pins_q <= nxt;
    // Data lines toggle outside a write, showing the last written value every other cycle
    lm_wr_q <= lm_req;
    lm_data_q <= lm_req ? lm_data : ~lm_data_q;
  end

  assign pins = pins_q;
  assign bp_lm_wr = lm_wr_q;
  assign bp_lm_wdata = lm_data_q;
endmodule

// [front_panel_reset_abort_status_tb.sv]
`timescale 1ns/1ns

module front_panel_reset_abort_status_tb
  import fpr_pkg::*;
;
  localparam int SR = 20;
  logic clock, sys_rst = 1'b1, watchdog_timeout = 1'b0;
  logic press = 1'b0, lm_req = 1'b0, ce = 1'b1;
  logic [3:0] lm_data = 4'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  fpr_pins_t pins, pins_req = '1;
  fpr_lamps_t lamps;
  logic bp_lm_wr, sr_oe, local_reset, hrst_n, abt_n, irq;
  logic [3:0] bp_lm_wdata, bp_lm_q;
  logic [2:0] lvl;
  logic [34:0] note_q[$];
  logic [34:0] nt;
  int err_count = 0, tests_run = 0, seed = 69, lw, ow, hn;

  fpr_ctrl #(.SYSRST_CYC(SR)) fpr_ctrl_i (
    .clock, .ce, .sys_rst,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pins, .watchdog_timeout,
    .bp_lm_wr, .bp_lm_wdata, .bp_lm_q, .bp_sysreset_o(),
    .bp_sysreset_oe(sr_oe), .local_reset, .processor_hard_reset_n(hrst_n),
    .abort_isa_interrupt_n(abt_n), .abort_irq_level(lvl), .irq, .lamps,
    .port_format_command()
  );

  fpr_board_model fpr_board_model_i (
    .clock, .press, .pins_req, .lm_req, .lm_data, .pins, .bp_lm_wr,
    .bp_lm_wdata
  );

  // Clock of 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic hung;
    err_count++;
    end_of_test;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rng(input int v, input int lo, input int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction

  // Write one word; the response is judged by the monitor
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    note_q.push_back({1'b0, er, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (!bvalid) hung;
  endtask

  // Read one word; expected data noted for the monitor
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    note_q.push_back({1'b1, er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (!rvalid) hung;
  endtask

  // Monitor pairs each bus answer with the oldest note
  always @(posedge clock) begin
    if (bvalid || rvalid) begin
      nt = '1;
      if (note_q.size() != 0) begin
        nt = note_q.pop_front();
      end
      check({30'h0, bvalid ? bresp : rresp}, {30'h0, nt[33:32]});
      if (rvalid) begin
        check(rdata, nt[31:0]);
      end
    end
  end

  // Tally reset outputs over a fixed window
  task automatic reset_span;
    lw = 0;
    ow = 0;
    hn = 0;
    repeat (60) begin
      @(posedge clock);
      lw += int'(local_reset === 1'b1);
      ow += int'(sr_oe === 1'b1);
      hn += int'(hrst_n !== ~local_reset);
    end
  endtask

  // Fire one reset source
  task automatic pulse_src(input int k);
    case (k)
      0, 1: begin
        pins_req.reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        pins_req.reset_n <= 1'b1;
      end
      2: begin
        watchdog_timeout <= 1'b1;
        @(posedge clock);
        watchdog_timeout <= 1'b0;
      end
      3: begin
        axi_wr(8'h00, 32'h10, 2'h0);
        axi_wr(8'h00, 32'h0, 2'h0);
      end
      default: begin
        pins_req.bp_sysreset_n <= 1'b0;
        repeat (3) @(posedge clock);
        pins_req.bp_sysreset_n <= 1'b1;
      end
    endcase
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    reset_span;
    check(rng(ow, SR, SR + 6), 32'h1);
    check(rng(lw, SR, SR + 6), 32'h1);
    axi_rd(8'h14, 32'h2710, 2'h0);
    axi_rd(8'h18, 32'h30041, 2'h0);
    axi_rd(8'h40, 32'h0, 2'h2);
    axi_wr(8'h40, 32'h1, 2'h2);
    axi_wr(8'h08, 32'hf, 2'h0);
    axi_rd(8'h08, 32'h2, 2'h0);
    axi_wr(8'h04, 32'h5, 2'h0);
    axi_rd(8'h04, 32'h5, 2'h0);
    lm_data <= 4'ha;
    lm_req <= 1'b1;
    @(posedge clock);
    lm_req <= 1'b0;
    repeat (3) @(posedge clock);
    check({28'h0, bp_lm_q}, 32'ha);
    axi_rd(8'h04, 32'ha, 2'h0);
    axi_rd(8'h0c, 32'h4, 2'h0);
    axi_wr(8'h0c, 32'h7, 2'h0);
    // Button, watchdog, software and backplane resets, strap off for the first
    for (int k = 0; k < 5; k++) begin
      pins_req.sys_ctrl <= (k != 0);
      repeat (4) @(posedge clock);
      fork
        reset_span;
        pulse_src(k);
      join
      check(rng(lw, k == 4 ? 1 : SR, k == 4 ? 8 : SR + 6), 32'h1);
      check(rng(ow, k % 4 ? SR : 0, k % 4 ? SR + 6 : 0), 32'h1);
      check(hn, 32'h0);
    end
    axi_rd(8'h0c, 32'h2, 2'h0);
    axi_wr(8'h0c, 32'h7, 2'h0);
    // Software hold keeps the board in reset
    axi_wr(8'h00, 32'h20, 2'h0);
    repeat (40) @(posedge clock);
    check({29'h0, local_reset, hrst_n, sr_oe}, 32'h4);
    check({30'h0, lamps.span_upper_lamp, lamps.span_lower_lamp}, 32'h3);
    axi_wr(8'h00, 32'h0, 2'h0);
    repeat (5) @(posedge clock);
    check({31'h0, local_reset}, 32'h0);
    // Random lamp inputs
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      pins_req.board_fail_n <= r[0];
      pins_req.bus_busy_n <= r[1];
      pins_req.pci_gnt_n <= r[3:2];
      pins_req.span_gnt_n <= r[5:4];
      repeat (6) @(posedge clock);
      check({26'h0, lamps}, {26'h0, ~r[0], ~r[1], ~r[3], ~r[2], ~r[5], ~r[4]});
    end
    // Clock enable low freezes the lamp path
    ce <= 1'b0;
    pins_req.board_fail_n <= 1'b0;
    repeat (6) @(posedge clock);
    check({31'h0, lamps.board_fail_lamp}, {31'h0, ~r[0]});
    ce <= 1'b1;
    repeat (6) @(posedge clock);
    check({31'h0, lamps.board_fail_lamp}, 32'h1);
    pins_req.board_fail_n <= 1'b1;
    repeat (6) @(posedge clock);
    // Bouncy abort press, enabled at level 5
    axi_wr(8'h14, 32'h3, 2'h0);
    axi_wr(8'h10, 32'h1, 2'h0);
    axi_wr(8'h00, 32'hb, 2'h0);
    press <= 1'b1;
    repeat (20) @(posedge clock);
    check({27'h0, abt_n, lvl, irq}, 32'h0b);
    axi_rd(8'h08, 32'h3, 2'h0);
    axi_rd(8'h0c, 32'h1, 2'h0);
    axi_wr(8'h0c, 32'h1, 2'h0);
    press <= 1'b0;
    repeat (20) @(posedge clock);
    axi_rd(8'h0c, 32'h0, 2'h0);
    axi_rd(8'h08, 32'h2, 2'h0);
    check({30'h0, abt_n, irq}, 32'h2);
    // Masked and disabled press still sets status
    axi_wr(8'h10, 32'h0, 2'h0);
    axi_wr(8'h00, 32'h0, 2'h0);
    press <= 1'b1;
    repeat (20) @(posedge clock);
    check({30'h0, abt_n, irq}, 32'h2);
    axi_rd(8'h0c, 32'h1, 2'h0);
    end_of_test;
  end
endmodule
